// ===== rtl/wrp_pkg.sv
package wrp_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CODE_W = 5;
    localparam logic [3:0] ADDR_PREFIX = 4'h5;
    localparam logic [1:0] ADDR_FACTORY_BITS = 2'h0;
    localparam logic [7:0] CMD_VOLATILE_WRITE = 8'h11;
    localparam logic [7:0] CMD_NONVOLATILE_WRITE = 8'h21;
    localparam logic [7:0] CMD_RECALL = 8'h61;
    localparam logic [7:0] CMD_STORE = 8'h51;
    localparam logic [CODE_W-1:0] NV_FACTORY_VALUE = 5'h00;
    localparam int DATA_CODE_MSB = 7;
    localparam int DATA_CODE_LSB = 3;
    localparam int POWERUP_TIME_NS = 20_000;
    localparam int POWERUP_CYCLES_RAW = POWERUP_TIME_NS / (1_000_000_000 / CLK_HZ);
    localparam int POWERUP_CYCLES = (POWERUP_CYCLES_RAW < 1) ? 1 : POWERUP_CYCLES_RAW;
    localparam int POWERUP_CNT_W = 8;
    localparam logic [POWERUP_CNT_W-1:0] POWERUP_LAST = POWERUP_CNT_W'(POWERUP_CYCLES - 1);
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_AFTER_START = 4'hF;

    typedef enum logic [2:0] {
        WRP_ST_IDLE,
        WRP_ST_ADDR,
        WRP_ST_CMD,
        WRP_ST_DATA,
        WRP_ST_EXTRA,
        WRP_ST_IGNORE
    } wrp_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } wrp_bus_t;

    typedef struct packed {
        logic wr_en;
        logic [CODE_W-1:0] wr_data;
    } wrp_nv_req_t;
endpackage

// ===== rtl/wrp_nv_store.sv
`timescale 1ns/1ns
`default_nettype none
module wrp_nv_store (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // write port
    input wire wrp_pkg::wrp_nv_req_t i_req,
    // read port
    output logic [wrp_pkg::CODE_W-1:0] o_rd_data
);
    import wrp_pkg::*;

    logic [CODE_W-1:0] cell_reg;
    logic [CODE_W-1:0] cell_next;

    always_comb begin
        cell_next = cell_reg;
        if (i_req.wr_en) begin
            cell_next = i_req.wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cell_reg <= NV_FACTORY_VALUE;
        end else begin
            cell_reg <= cell_next;
        end
    end

    assign o_rd_data = cell_reg;
endmodule
`default_nettype wire

// ===== rtl/wrp_wiper_i2c_slave.sv
// Summary of operation
// - address 0101 plus two fixed bits 00 and one pin select bit
// - eighth bit high means no operation
// - pull data low on ninth clock
// - first byte command, later bytes data
// - first data byte to selected register
// - decode four command byte codes
// - wiper code from data bits seven-three
// - volatile write moves wiper at once
// - nonvolatile write leaves wiper alone
// - recall copies stored code to wiper
// - store copies wiper code to storage
// - storage is one five-bit register
// - storage starts at all zeros
// - power-up loads stored code to wiper
// - power-up load within twenty microseconds
// - standby after power-up load when idle or when ignoring a transaction (other address or read)
`timescale 1ns/1ns
`default_nettype none
module wrp_wiper_i2c_slave (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // address select pin
    input wire logic i_address_select_input,
    // wiper and status
    output logic [wrp_pkg::CODE_W-1:0] o_wiper,
    output logic o_standby,
    output logic o_init_done
);
    import wrp_pkg::*;

    wrp_bus_t sync1_reg;
    wrp_bus_t sync2_reg;
    wrp_bus_t prev_reg;
    logic asel1_reg;
    logic asel2_reg;

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync1_reg <= '{scl: 1'b1, sda: 1'b1};
            sync2_reg <= '{scl: 1'b1, sda: 1'b1};
            prev_reg <= '{scl: 1'b1, sda: 1'b1};
            asel1_reg <= 1'b0;
            asel2_reg <= 1'b0;
        end else begin
            sync1_reg <= '{scl: i_scl, sda: i_sda};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            asel1_reg <= i_address_select_input;
            asel2_reg <= asel1_reg;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise = sync2_reg.scl && !prev_reg.scl;
    assign scl_fall = !sync2_reg.scl && prev_reg.scl;
    assign start_cond = sync2_reg.scl && prev_reg.scl && prev_reg.sda && !sync2_reg.sda;
    assign stop_cond = sync2_reg.scl && prev_reg.scl && !prev_reg.sda && sync2_reg.sda;

    function automatic logic addr_match(input logic [7:0] b, input logic sel);
        addr_match = (b[7:4] == ADDR_PREFIX) && (b[3:2] == ADDR_FACTORY_BITS) && (b[1] == sel);
    endfunction

    wrp_state_t state_reg;
    wrp_state_t state_next;
    logic [3:0] bit_reg;
    logic [3:0] bit_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] cmd_reg;
    logic [7:0] cmd_next;
    logic ack_reg;
    logic ack_next;
    logic [CODE_W-1:0] vol_reg;
    logic [CODE_W-1:0] vol_next;
    logic [POWERUP_CNT_W-1:0] pu_cnt_reg;
    logic [POWERUP_CNT_W-1:0] pu_cnt_next;
    logic init_reg;
    logic init_next;
    logic standby_reg;
    logic standby_next;
    wrp_nv_req_t nv_req;
    logic [CODE_W-1:0] nv_data;

    wrp_nv_store u_nv (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_req(nv_req),
        .o_rd_data(nv_data)
    );

    always_comb begin
        logic [7:0] byte_in;
        logic [CODE_W-1:0] code;
        byte_in = shift_reg;
        code = shift_reg[DATA_CODE_MSB:DATA_CODE_LSB];
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        cmd_next = cmd_reg;
        ack_next = ack_reg;
        vol_next = vol_reg;
        pu_cnt_next = pu_cnt_reg;
        init_next = init_reg;
        nv_req = '{wr_en: 1'b0, wr_data: '0};
        if (!init_reg) begin
            if (pu_cnt_reg == POWERUP_LAST) begin
                init_next = 1'b1;
                vol_next = nv_data;
            end else begin
                pu_cnt_next = pu_cnt_reg + POWERUP_CNT_W'(1);
            end
        end else if (start_cond) begin
            state_next = WRP_ST_ADDR;
            // scl fall that follows start wraps count to zero
            bit_next = BIT_AFTER_START;
            ack_next = 1'b0;
        end else if (stop_cond) begin
            state_next = WRP_ST_IDLE;
            ack_next = 1'b0;
        end else if (state_reg != WRP_ST_IDLE && state_reg != WRP_ST_IGNORE) begin
            if (scl_rise && bit_reg < BIT_ACK) begin
                shift_next = {shift_reg[6:0], sync2_reg.sda};
            end
            if (scl_fall) begin
                if (bit_reg == BIT_LAST_DATA) begin
                    bit_next = BIT_ACK;
                    ack_next = 1'b1;
                    case (state_reg)
                        WRP_ST_ADDR: begin
                            if (!addr_match(byte_in, asel2_reg) || byte_in[0]) begin
                                ack_next = addr_match(byte_in, asel2_reg);
                            end
                        end
                        WRP_ST_CMD: cmd_next = byte_in;
                        WRP_ST_DATA: begin
                            case (cmd_reg)
                                CMD_VOLATILE_WRITE: vol_next = code;
                                CMD_NONVOLATILE_WRITE: nv_req = '{wr_en: 1'b1, wr_data: code};
                                CMD_RECALL: vol_next = nv_data;
                                CMD_STORE: nv_req = '{wr_en: 1'b1, wr_data: vol_reg};
                                default: vol_next = vol_reg;
                            endcase
                        end
                        default: ack_next = 1'b1;
                    endcase
                end else if (bit_reg == BIT_ACK) begin
                    bit_next = '0;
                    ack_next = 1'b0;
                    case (state_reg)
                        WRP_ST_ADDR: begin
                            if (addr_match(shift_reg, asel2_reg) && !shift_reg[0]) begin
                                state_next = WRP_ST_CMD;
                            end else begin
                                state_next = WRP_ST_IGNORE;
                            end
                        end
                        WRP_ST_CMD: state_next = WRP_ST_DATA;
                        default: state_next = WRP_ST_EXTRA;
                    endcase
                end else begin
                    bit_next = bit_reg + 4'h1;
                end
            end
        end
        standby_next = init_next && (state_next == WRP_ST_IDLE || state_next == WRP_ST_IGNORE);
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= WRP_ST_IDLE;
            bit_reg <= '0;
            shift_reg <= '0;
            cmd_reg <= '0;
            ack_reg <= 1'b0;
            vol_reg <= '0;
            pu_cnt_reg <= '0;
            init_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            cmd_reg <= cmd_next;
            ack_reg <= ack_next;
            vol_reg <= vol_next;
            pu_cnt_reg <= pu_cnt_next;
            init_reg <= init_next;
            standby_reg <= standby_next;
        end
    end

    assign o_sda_oe = ack_reg;
    assign o_wiper = vol_reg;
    assign o_standby = standby_reg;
    assign o_init_done = init_reg;
endmodule
`default_nettype wire

// ===== sim/wrp_wiper_checker.sv
`timescale 1ns/1ns
`default_nettype none
module wrp_wiper_checker (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // watched outputs
    input wire logic o_sda_oe,
    input wire logic [wrp_pkg::CODE_W-1:0] o_wiper,
    input wire logic o_standby,
    input wire logic o_init_done
);
    import wrp_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    property p_init_time; $rose(i_arst_n) |-> ##[1:200] o_init_done; endproperty
    property p_init_value; $rose(o_init_done) |-> o_wiper == NV_FACTORY_VALUE; endproperty
    property p_init_stays; o_init_done |=> o_init_done; endproperty
    property p_quiet_init; !o_init_done |-> !o_standby && !o_sda_oe; endproperty
    property p_wiper_ack; $past(o_init_done) && $changed(o_wiper) |-> $rose(o_sda_oe); endproperty
    property p_ack_awake; $rose(o_sda_oe) |-> !$past(o_standby); endproperty
    property p_ack_hold; $rose(o_sda_oe) |-> o_sda_oe [*5]; endproperty
    property p_ack_free; $rose(o_sda_oe) |-> ##[1:12] !o_sda_oe; endproperty
    a_init_time: assert property (p_init_time) else $error("load late");
    a_init_value: assert property (p_init_value) else $error("bad start code");
    a_init_stays: assert property (p_init_stays) else $error("init lost");
    a_quiet_init: assert property (p_quiet_init) else $error("busy in init");
    a_wiper_ack: assert property (p_wiper_ack) else $error("wiper moved off ack");
    a_ack_awake: assert property (p_ack_awake) else $error("ack in standby");
    a_ack_hold: assert property (p_ack_hold) else $error("ack short");
    a_ack_free: assert property (p_ack_free) else $error("ack stuck");
    c_ack: cover property ($rose(o_sda_oe));
    c_wake: cover property ($fell(o_standby));
    c_move: cover property ($past(o_init_done) && $changed(o_wiper));
endmodule
bind wrp_wiper_i2c_slave wrp_wiper_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .o_sda_oe(o_sda_oe),
    .o_wiper(o_wiper), .o_standby(o_standby), .o_init_done(o_init_done));
`default_nettype wire

// ===== sim/wrp_bus_master.sv
`timescale 1ns/1ns
`default_nettype none
module wrp_bus_master (
    // clock
    input wire logic i_clk,
    // bus
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic frame(input logic [31:0] b, input int n, output int acks);
        acks = 0;
        o_sda_oe <= 1'b1;
        tick(4);
        for (int k = 0; k < n * 9; k++) begin
            o_scl <= 1'b0;
            tick(2);
            o_sda_oe <= (k % 9 == 8) ? 1'b0 : !b[31 - k / 9 * 8 - k % 9 % 8];
            tick(2);
            o_scl <= 1'b1;
            tick(2);
            acks += (k % 9 == 8 && i_sda === 1'b0) ? 1 : 0;
            tick(2);
        end
        o_scl <= 1'b0;
        tick(2);
        o_sda_oe <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_oe <= 1'b0;
        tick(8);
    endtask
endmodule
`default_nettype wire

// ===== sim/wrp_wiper_i2c_slave_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wrp_wiper_i2c_slave_tb;
    import wrp_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic a0 = 1'b0;
    logic scl, m_oe, d_oe, stby, done;
    logic [CODE_W-1:0] wiper;
    wire logic sda = !(m_oe || d_oe);
    int failures = 0;
    int cmp_count = 0;
    int acks;
    logic [7:0] adr = {ADDR_PREFIX, ADDR_FACTORY_BITS, 2'h2};
    always #50 clk = ~clk;
    wrp_wiper_i2c_slave u_dut (.i_clk(clk), .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda_oe(d_oe),
        .i_address_select_input(a0), .o_wiper(wiper), .o_standby(stby), .o_init_done(done));
    wrp_bus_master u_mst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic t_powerup;
        repeat (202) @(posedge clk);
        check({7'h00, done}, 8'h01);
        check({3'h0, wiper}, {3'h0, NV_FACTORY_VALUE});
        check({7'h00, stby}, 8'h01);
        $display("powerup done");
    endtask
    task automatic t_vol;
        fork
            u_mst.frame({adr, CMD_VOLATILE_WRITE, 8'hAF, 8'h00}, 3, acks);
            begin
                repeat (100) @(posedge clk);
                check({7'h00, stby}, 8'h00);
            end
        join
        check(8'(acks), 8'h03);
        check({3'h0, wiper}, 8'h15);
        check({7'h00, stby}, 8'h01);
        $display("volatile write done");
    endtask
    task automatic t_cmds;
        logic [7:0] cmd [6] = '{CMD_NONVOLATILE_WRITE, CMD_RECALL, CMD_VOLATILE_WRITE, CMD_STORE,
            CMD_VOLATILE_WRITE, CMD_RECALL};
        logic [7:0] dat [6] = '{8'h38, 8'hFF, 8'h08, 8'hF8, 8'hF8, 8'h00};
        logic [7:0] exp [6] = '{8'h15, 8'h07, 8'h01, 8'h01, 8'h1F, 8'h01};
        for (int i = 0; i < 6; i++) begin
            u_mst.frame({adr, cmd[i], dat[i], 8'h00}, 3, acks);
            check(8'(acks), 8'h03);
            check({3'h0, wiper}, exp[i]);
        end
        $display("command set done");
    endtask
    task automatic t_refuse;
        logic [31:0] frm [4] = '{{adr ^ 8'h02, 24'h110000}, {adr | 8'h01, 24'h110000}, {adr, 24'h000000},
            {adr, 24'h1140F8}};
        int len [4] = '{3, 3, 3, 4};
        logic [7:0] ack_exp [4] = '{8'h00, 8'h01, 8'h03, 8'h04};
        logic [7:0] exp [4] = '{8'h01, 8'h01, 8'h01, 8'h08};
        for (int i = 0; i < 4; i++) begin
            u_mst.frame(frm[i], len[i], acks);
            check(8'(acks), ack_exp[i]);
            check({3'h0, wiper}, exp[i]);
        end
        $display("refusals done");
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        a0 <= 1'b1;
        t_powerup();
        t_vol();
        t_cmds();
        t_refuse();
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_powerup();
        summarize();
    end
endmodule
`default_nettype wire
